// >>> rtl/fcs_sequencer.sv
// Fast-charge sequencer: start, discharge, fast-charge, top-off and trickle control.
// Assumes all inputs are synchronous to clk_i and readings are 12-bit codes of the supply.
//
// Behaviour
// - With battery and supply present and discharge low, charge rising edge starts fast-charge.
// - With battery and supply present and discharge high, charge falling edge starts fast-charge.
// - Discharge command rising edge starts discharge-before-charge.
// - Discharge drive high while discharging; phase ends when cell below 0.2 supply.
// - While discharging, LED low 1.375 s then high 0.125 s, repeating.
// - In fast-charge with sense resistor, switch on when sense below 0.044 supply.
// - Switch off when sense above 0.050 supply; keep state in between.
// - With sense grounded, switch stays on until a termination occurs.
// - Thermistor sampled every 34 s, compared with 68 s earlier; drop beyond 0.0032 ends.
// - Pulsed-trickle variant picks the slope sampling interval from rate select.
// - Slope termination only with thermistor between low fault and cutoff levels.
// - Cell sampled every 34 s; drop of more than 12 mV below maximum ends.
// - Negative delta only with cell between max reference and reference minus 0.2.
// - Negative delta suppressed during hold-off, monitored after it expires.
// - Thermistor past cutoff or past low fault at 0.4 supply ends fast-charge.
// - Cell voltage above max reference ends fast-charge.
// - Over-voltage during hold-off continues charge until hold-off expires, then ends.
// - Rate-selected maximum timeout ends fast-charge.
// - Status LED held low throughout fast-charge.
// - Base top-off: switch on 4 s, off 30 s, until timeout or safety limit.
// - Top-off LED toggles low and high every 0.125 s.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer #(
	parameter int TICK_CYCLES = fcs_pkg::TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Presence and command pins
	input wire logic battery_present_i,
	input wire logic supply_present_i,
	input wire logic charge_command_in_i,
	input wire logic discharge_command_in_i,
	input wire logic [1:0] rate_select_a_i,
	input wire logic [1:0] rate_select_b_i,
	// Comparator results and readings
	input wire logic sense_below_low_i,
	input wire logic sense_above_high_i,
	input wire logic [fcs_pkg::ADC_W-1:0] cell_voltage_in_i,
	input wire logic [fcs_pkg::ADC_W-1:0] thermistor_in_i,
	input wire logic [fcs_pkg::ADC_W-1:0] temp_cutoff_ref_in_i,
	input wire logic [fcs_pkg::ADC_W-1:0] max_cell_voltage_ref_in_i,
	// Drives
	output logic charge_switch_out_o,
	output logic discharge_drive_out_o,
	output logic status_led_out_o
);
	import fcs_pkg::*;

	fcs_tb_if tb ();

	fcs_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_tb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tb(tb)
	);

	// Rate-select pin level: ground, open or supply
	function automatic int lvl(input logic [1:0] p);
		return (p == LVL_GND) ? 0 : ((p == LVL_OPEN) ? 1 : 2);
	endfunction

	// Row of the rate table
	function automatic int rate_idx(input logic [1:0] a, input logic [1:0] b);
		return lvl(a) + 3 * lvl(b);
	endfunction

	// At-or-above compare of a 24-bit elapsed count against ticks
	function automatic logic reached(input logic [TB_W-1:0] el, input int ticks);
		return el >= TB_W'(ticks);
	endfunction

	fcs_state_e state, next_state;
	fcs_cause_e cause, next_cause;
	logic [7:0] ctrl;
	logic charge_command_in_q, discharge_command_in_q;
	logic [TB_W-1:0] stamp, elapsed;
	logic [9:0] dv_cnt;
	logic [12:0] slope_cnt;
	logic [10:0] pulse_cnt;
	logic [3:0] led_cnt;
	logic [ADC_W-1:0] ts_s1, ts_s2, cell_max;
	logic [1:0] ts_n;
	logic have_max, vmax_seen, hyst_on;
	logic next_switch, next_led, next_hyst;
	int idx;
	int slope_ticks, pulse_on, pulse_per;
	logic present, start_req, disch_req, sense_gnd, variant_a, topoff_en;
	logic dv_tick, slope_tick, holdoff_done, timed_out;
	logic t_high, t_low, vmax, slope_win, ndv_win, slope_hit, ndv_hit, term_any;

	// Operating decodes
	assign idx = rate_idx(rate_select_a_i, rate_select_b_i);
	assign present = battery_present_i & supply_present_i;
	assign sense_gnd = ctrl[CTRL_SENSE_GND_BIT];
	assign variant_a = ctrl[CTRL_VARIANT_BIT];
	assign topoff_en = idx >= TOPOFF_FIRST_IDX;
	assign start_req = present & (discharge_command_in_i ?
		(charge_command_in_q & ~charge_command_in_i) :
		(~charge_command_in_q & charge_command_in_i));
	assign disch_req = present & discharge_command_in_i & ~discharge_command_in_q;
	assign elapsed = tb.count - stamp;

	// Slope interval fixed at 34 s unless the pulsed variant is selected
	assign slope_ticks = variant_a ? SLOPE_A_S[idx] * TICKS_PER_SEC : ms2t(SAMPLE_MS);
	assign dv_tick = tb.tick & (dv_cnt == 10'(ms2t(SAMPLE_MS) - 1));
	assign slope_tick = tb.tick & (slope_cnt == 13'(slope_ticks - 1));
	assign holdoff_done = reached(elapsed, HOLDOFF_S[idx] * TICKS_PER_SEC);
	assign timed_out = reached(elapsed, TIMEOUT_MIN[idx] * TICKS_PER_MIN);

	// Safety limits; the thermistor falls as temperature rises
	assign t_high = thermistor_in_i < temp_cutoff_ref_in_i;
	assign t_low = thermistor_in_i > LTF_CODE;
	assign vmax = cell_voltage_in_i > max_cell_voltage_ref_in_i;
	assign slope_win = ~t_high & ~t_low;
	assign ndv_win = ~vmax & ({1'b0, cell_voltage_in_i} + {1'b0, EDV_CODE} >=
		{1'b0, max_cell_voltage_ref_in_i});
	assign slope_hit = slope_tick & slope_win & (ts_n == 2'h2) &
		({1'b0, thermistor_in_i} + {1'b0, SLOPE_CODE} < {1'b0, ts_s2});
	assign ndv_hit = dv_tick & holdoff_done & ndv_win & have_max &
		({1'b0, cell_voltage_in_i} + {1'b0, NDV_CODE} < {1'b0, cell_max});
	assign term_any = (next_cause != CAUSE_NONE);

	// Termination cause, safety limits take priority
	always_comb begin
		next_cause = CAUSE_NONE;
		if (t_high) begin
			next_cause = CAUSE_TEMP_HIGH;
		end else if (t_low) begin
			next_cause = CAUSE_TEMP_LOW;
		end else if (holdoff_done & (vmax | vmax_seen)) begin
			next_cause = CAUSE_VOLT_MAX;
		end else if (ndv_hit) begin
			next_cause = CAUSE_NDV;
		end else if (slope_hit) begin
			next_cause = CAUSE_SLOPE;
		end else if (timed_out) begin
			next_cause = CAUSE_TIMEOUT;
		end
	end

	// Sequencer transitions
	always_comb begin
		next_state = state;
		case (state)
			ST_DISCHARGE: begin
				if (cell_voltage_in_i < EDV_CODE) begin
					next_state = ST_FAST;
				end
			end
			ST_FAST: begin
				if (term_any) begin
					next_state = topoff_en ? ST_TOPOFF : ST_TRICKLE;
				end
			end
			ST_PENDING, ST_TOPOFF, ST_TRICKLE: begin
				if (disch_req) begin
					next_state = ST_DISCHARGE;
				end else if (start_req) begin
					next_state = ST_FAST;
				end else if (state == ST_TOPOFF & (timed_out | t_high | t_low | vmax)) begin
					next_state = ST_TRICKLE;
				end
			end
			default: begin
				next_state = ST_PENDING;
			end
		endcase
		if (!present) begin
			next_state = ST_PENDING;
		end
	end

	// State register and entry time stamp
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_PENDING;
			stamp <= '0;
		end else begin
			state <= next_state;
			if (next_state != state) begin
				stamp <= tb.count;
			end
		end
	end

	// First termination cause is kept until the next fast-charge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cause <= CAUSE_NONE;
		end else if (state != ST_FAST & next_state == ST_FAST) begin
			cause <= CAUSE_NONE;
		end else if (state == ST_FAST & cause == CAUSE_NONE) begin
			cause <= next_cause;
		end
	end

	// Command edge history, tracked through reset so a pin held high gives no false edge
	always_ff @(posedge clk_i) begin
		charge_command_in_q <= charge_command_in_i;
		discharge_command_in_q <= discharge_command_in_i;
	end

	// Sample interval counters restart with every fast-charge
	always_ff @(posedge clk_i) begin
		if (rst_i || next_state != state) begin
			dv_cnt <= 10'h0;
			slope_cnt <= 13'h0;
		end else if (tb.tick) begin
			dv_cnt <= dv_tick ? 10'h0 : dv_cnt + 10'h1;
			slope_cnt <= slope_tick ? 13'h0 : slope_cnt + 13'h1;
		end
	end

	// Thermistor history, two samples deep
	always_ff @(posedge clk_i) begin
		if (rst_i || next_state != state) begin
			ts_s1 <= '0;
			ts_s2 <= '0;
			ts_n <= 2'h0;
		end else if (state == ST_FAST && slope_tick) begin
			ts_s1 <= thermistor_in_i;
			ts_s2 <= ts_s1;
			if (ts_n != 2'h2) begin
				ts_n <= ts_n + 2'h1;
			end
		end
	end

	// Highest cell sample, tracked through hold-off too
	always_ff @(posedge clk_i) begin
		if (rst_i || next_state != state) begin
			cell_max <= '0;
			have_max <= 1'b0;
		end else if (state == ST_FAST && dv_tick) begin
			have_max <= 1'b1;
			if (!have_max || cell_voltage_in_i > cell_max) begin
				cell_max <= cell_voltage_in_i;
			end
		end
	end

	// Over-voltage seen early is remembered so it ends charge at hold-off expiry
	always_ff @(posedge clk_i) begin
		if (rst_i || next_state != state) begin
			vmax_seen <= 1'b0;
		end else if (state == ST_FAST && vmax) begin
			vmax_seen <= 1'b1;
		end
	end

	// Sense comparator with hysteresis; the switch uses the new value, so it
	// drops one cycle after the high threshold instead of two
	always_comb begin
		next_hyst = hyst_on;
		if (sense_above_high_i) begin
			next_hyst = 1'b0;
		end else if (sense_below_low_i) begin
			next_hyst = 1'b1;
		end
	end

	// Comparator state between the thresholds
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hyst_on <= 1'b0;
		end else begin
			hyst_on <= next_hyst;
		end
	end

	// Pulse window for top-off and pulsed trickle
	always_comb begin
		pulse_on = 0;
		pulse_per = 1;
		if (state == ST_TOPOFF) begin
			pulse_on = variant_a ? ms2t(TOPOFF_A_ON_MS) : ms2t(TOPOFF_ON_MS);
			pulse_per = pulse_on + (variant_a ? ms2t(TOPOFF_A_OFF_MS) : ms2t(TOPOFF_OFF_MS));
		end else if (state == ST_TRICKLE && variant_a) begin
			pulse_on = ms2t(TRICKLE_ON_MS[idx]);
			pulse_per = pulse_on + TRICKLE_OFF_S[idx] * TICKS_PER_SEC;
		end
	end

	// Pattern counters, both on the shared tick
	always_ff @(posedge clk_i) begin
		if (rst_i || next_state != state) begin
			pulse_cnt <= 11'h0;
			led_cnt <= 4'h0;
		end else if (tb.tick) begin
			pulse_cnt <= (pulse_cnt >= 11'(pulse_per - 1)) ? 11'h0 : pulse_cnt + 11'h1;
			led_cnt <= (led_cnt >= 4'(ms2t(LED_LONG_MS + LED_SHORT_MS) - 1)) ?
				4'h0 : led_cnt + 4'h1;
		end
	end

	// Drive decisions; the LED pin is active low
	always_comb begin
		next_switch = 1'b0;
		next_led = 1'b1;
		case (next_state)
			ST_PENDING: begin
				next_led = ~(battery_present_i & (led_cnt < 4'(ms2t(LED_SHORT_MS))));
			end
			ST_DISCHARGE: begin
				next_led = ~(led_cnt < 4'(ms2t(LED_LONG_MS)));
			end
			ST_FAST: begin
				next_switch = sense_gnd | next_hyst;
				next_led = 1'b0;
			end
			ST_TOPOFF, ST_TRICKLE: begin
				next_switch = (pulse_cnt < 11'(pulse_on)) & (sense_gnd | next_hyst);
				next_led = elapsed[0];
			end
			default: begin
				next_switch = 1'b0;
			end
		endcase
	end

	// Registered drives
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			charge_switch_out_o <= 1'b0;
			discharge_drive_out_o <= 1'b0;
			status_led_out_o <= 1'b1;
		end else begin
			charge_switch_out_o <= next_switch;
			discharge_drive_out_o <= (next_state == ST_DISCHARGE);
			status_led_out_o <= next_led;
		end
	end

	// Wishbone: one wait state, ack drops the cycle after it was given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			ctrl <= CTRL_RESET;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= 32'h0;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				if (wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
					ctrl <= wb_dat_i[7:0];
				end
				if (!wb_we_i && wb_adr_i == REG_CTRL) begin
					wb_dat_o <= {24'h0, ctrl};
				end
				if (!wb_we_i && wb_adr_i == REG_STATUS) begin
					wb_dat_o[ST_STATE_LSB +: 3] <= state;
					wb_dat_o[ST_CAUSE_LSB +: 3] <= cause;
					wb_dat_o[ST_SWITCH_BIT] <= charge_switch_out_o;
					wb_dat_o[ST_DISCH_BIT] <= discharge_drive_out_o;
					wb_dat_o[ST_LED_BIT] <= status_led_out_o;
					wb_dat_o[ST_TOPOFF_EN_BIT] <= topoff_en;
				end
			end
		end
	end
endmodule // fcs_sequencer
`default_nettype wire

// >>> rtl/fcs_pkg.sv
// Constants, tables and types for the fast-charge sequencer.
// Assumes a 200 MHz clock and 12-bit readings with full scale at the supply voltage.
package fcs_pkg;
	// Clock and time base
	localparam int CLK_MHZ = 200;
	localparam int TICK_PERIOD_MS = 125;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_MS * 1000 * CLK_MHZ;
	localparam int TICKS_PER_SEC = 1000 / TICK_PERIOD_MS;
	localparam int TICKS_PER_MIN = 60 * TICKS_PER_SEC;
	localparam int TB_W = 24;

	// Pattern and sampling times in milliseconds
	localparam int LED_LONG_MS = 1375;
	localparam int LED_SHORT_MS = 125;
	localparam int SAMPLE_MS = 34000;
	localparam int TOPOFF_ON_MS = 4000;
	localparam int TOPOFF_OFF_MS = 30000;
	localparam int TOPOFF_A_ON_MS = 500;
	localparam int TOPOFF_A_OFF_MS = 3500;

	// Analog scale: codes relative to the supply voltage
	localparam int ADC_W = 12;
	localparam int ADC_FS = 4096;
	localparam int VREF_MV = 5000;
	localparam int NDV_MV = 12;
	localparam logic [ADC_W-1:0] EDV_CODE = ADC_W'(ADC_FS * 2 / 10);
	localparam logic [ADC_W-1:0] LTF_CODE = ADC_W'(ADC_FS * 4 / 10);
	localparam logic [ADC_W-1:0] SLOPE_CODE = ADC_W'(ADC_FS * 32 / 10000);
	localparam logic [ADC_W-1:0] NDV_CODE = ADC_W'(ADC_FS * NDV_MV / VREF_MV);

	// Rate-select table, indexed by level(a) + 3 * level(b)
	localparam int RATE_ROWS = 9;
	localparam int TOPOFF_FIRST_IDX = 5;
	localparam int TIMEOUT_MIN [0:8] = '{360, 180, 90, 45, 23, 180, 90, 45, 23};
	localparam int HOLDOFF_S [0:8] = '{140, 820, 410, 200, 100, 820, 410, 200, 100};
	localparam int SLOPE_A_S [0:8] = '{544, 544, 136, 68, 68, 544, 136, 68, 68};
	localparam int TRICKLE_ON_MS [0:8] = '{0, 1000, 1000, 1000, 1000, 500, 500, 500, 500};
	localparam int TRICKLE_OFF_S [0:8] = '{0, 16, 32, 64, 128, 16, 32, 64, 128};
	localparam logic [1:0] LVL_GND = 2'h0;
	localparam logic [1:0] LVL_OPEN = 2'h1;

	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int CTRL_SENSE_GND_BIT = 0;
	localparam int CTRL_VARIANT_BIT = 1;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_CAUSE_LSB = 4;
	localparam int ST_SWITCH_BIT = 8;
	localparam int ST_DISCH_BIT = 9;
	localparam int ST_LED_BIT = 10;
	localparam int ST_TOPOFF_EN_BIT = 11;

	typedef enum logic [2:0] {
		ST_PENDING = 3'h0,
		ST_DISCHARGE = 3'h1,
		ST_FAST = 3'h2,
		ST_TOPOFF = 3'h3,
		ST_TRICKLE = 3'h4
	} fcs_state_e;

	typedef enum logic [2:0] {
		CAUSE_NONE = 3'h0,
		CAUSE_SLOPE = 3'h1,
		CAUSE_NDV = 3'h2,
		CAUSE_TEMP_HIGH = 3'h3,
		CAUSE_TEMP_LOW = 3'h4,
		CAUSE_VOLT_MAX = 3'h5,
		CAUSE_TIMEOUT = 3'h6
	} fcs_cause_e;

	// Milliseconds to time-base ticks
	function automatic int ms2t(input int ms);
		return ms / TICK_PERIOD_MS;
	endfunction
endpackage

// >>> rtl/fcs_tb_if.sv
// Time-base carrier between the prescaler and the sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface fcs_tb_if;
	logic tick;
	logic [fcs_pkg::TB_W-1:0] count;
	modport src (output tick, output count);
	modport dst (input tick, input count);
endinterface
`default_nettype wire

// >>> rtl/fcs_timebase.sv
// Free-running time base: one tick every 0.125 s and a running tick count.
// Assumes synchronous active-high reset; TICK_CYCLES may be shortened for simulation.
`timescale 1ns/1ps
`default_nettype none
module fcs_timebase #(
	parameter int TICK_CYCLES = fcs_pkg::TICK_CYCLES_DEF
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Tick output
	fcs_tb_if.src tb
);
	import fcs_pkg::*;

	logic [31:0] pre;

	// Prescaler; the tick is a one-cycle pulse at wrap
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre <= 32'h0;
			tb.tick <= 1'b0;
		end else if (pre == 32'(TICK_CYCLES - 1)) begin
			pre <= 32'h0;
			tb.tick <= 1'b1;
		end else begin
			pre <= pre + 32'h1;
			tb.tick <= 1'b0;
		end
	end

	// Tick count never stops, so hold-off and timeout intervals are measured against it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tb.count <= '0;
		end else if (tb.tick) begin
			tb.count <= tb.count + TB_W'(1);
		end
	end
endmodule // fcs_timebase
`default_nettype wire

// >>> verification/fcs_seq_sva.sv
// Port checker for the fast-charge sequencer.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fcs_seq_sva #(
	parameter int TICK_CYCLES = 4
) (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Pins
	input wire logic battery_present_i,
	input wire logic supply_present_i,
	input wire logic charge_command_in_i,
	input wire logic discharge_command_in_i,
	input wire logic sense_above_high_i,
	input wire logic [fcs_pkg::ADC_W-1:0] cell_voltage_in_i,
	input wire logic charge_switch_out_o,
	input wire logic discharge_drive_out_o,
	input wire logic status_led_out_o
);
	import fcs_pkg::*;
	localparam int LO_MAX = 12 * TICK_CYCLES;
	int lo_run;
	logic present;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Presence of both battery and supply gates every command
	assign present = battery_present_i && supply_present_i;
	// Low run of the LED while discharging; a stuck LED makes it grow past a period
	always_ff @(posedge clk_i) begin
		if (rst_i || !discharge_drive_out_o || status_led_out_o) begin
			lo_run <= 0;
		end else begin
			lo_run <= lo_run + 1;
		end
	end
	a_reset_idle: assert property ($fell(rst_i) |-> !charge_switch_out_o
		&& !discharge_drive_out_o && status_led_out_o && !wb_ack_o)
		else $error("outputs not idle after reset");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus answer late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_start_rise: assert property (present && $rose(charge_command_in_i)
		&& !discharge_command_in_i && !discharge_drive_out_o
		|=> !status_led_out_o && !discharge_drive_out_o) else $error("no start on rise");
	a_start_fall: assert property (present && $fell(charge_command_in_i)
		&& discharge_command_in_i && $stable(discharge_command_in_i) && !discharge_drive_out_o
		|=> !status_led_out_o && !discharge_drive_out_o) else $error("no start on fall");
	a_disch_begin: assert property (present && $rose(discharge_command_in_i)
		|=> discharge_drive_out_o) else $error("discharge not started");
	a_disch_end: assert property (discharge_drive_out_o && cell_voltage_in_i < EDV_CODE
		|=> !discharge_drive_out_o && !status_led_out_o) else $error("discharge not ended");
	a_switch_off: assert property (sense_above_high_i |=> !charge_switch_out_o)
		else $error("switch on above high threshold");
	a_led_period: assert property (discharge_drive_out_o |-> lo_run < LO_MAX)
		else $error("discharge LED low too long");
	// Main scenarios reached
	c_disch: cover property ($rose(discharge_drive_out_o));
	c_disch_end: cover property ($fell(discharge_drive_out_o));
	c_hyst: cover property (sense_above_high_i ##1 !charge_switch_out_o);
endmodule // fcs_seq_sva
bind fcs_sequencer fcs_seq_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.clk_i, .rst_i,
	.wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .battery_present_i, .supply_present_i,
	.charge_command_in_i, .discharge_command_in_i, .sense_above_high_i, .cell_voltage_in_i,
	.charge_switch_out_o, .discharge_drive_out_o, .status_led_out_o);
`default_nettype wire

// >>> verification/fcs_pack_model.sv
// Pack and sense resistor model: inductor current ramps with the switch.
// Assumes the switch input is synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module fcs_pack_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Switch drive and sense strap
	input wire logic switch_i,
	input wire logic ground_sense_i,
	// Comparator results
	output logic below_low_o,
	output logic above_high_o
);
	logic [3:0] level;
	// Current rises while switched on, decays while off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level <= 4'h0;
		end else if (switch_i && level != 4'hF) begin
			level <= level + 4'h1;
		end else if (!switch_i && level != 4'h0) begin
			level <= level - 4'h1;
		end
	end
	// Grounded sense reads zero, so only the low comparator trips
	assign below_low_o = ground_sense_i || level < 4'h4;
	assign above_high_o = !ground_sense_i && level > 4'hA;
endmodule // fcs_pack_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the fast-charge sequencer.
// Assumes a shortened time base of four clocks per tick.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
	import fcs_pkg::*;
	localparam int TC = 4;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic wb_ack_o, battery_present_i = 1'b1, supply_present_i = 1'b1, gnd = 1'b0;
	logic charge_command_in_i = 1'b0, discharge_command_in_i = 1'b0;
	logic [1:0] rate_select_a_i = 2'h0, rate_select_b_i = 2'h0;
	logic sense_below_low_i, sense_above_high_i;
	logic [ADC_W-1:0] cell_voltage_in_i = 12'h5DC, thermistor_in_i = 12'h514;
	logic [ADC_W-1:0] temp_cutoff_ref_in_i = 12'h3E8, max_cell_voltage_ref_in_i = 12'h640;
	logic charge_switch_out_o, discharge_drive_out_o, status_led_out_o;
	int err_total = 0, checked = 0, hi;
	always #2.5 clk_i = ~clk_i;
	fcs_sequencer #(.TICK_CYCLES(TC)) dut (.*);
	fcs_pack_model pack (.clk_i, .rst_i, .switch_i(charge_switch_out_o), .ground_sense_i(gnd),
		.below_low_o(sense_below_low_i), .above_high_o(sense_above_high_i));
	task automatic conclude();
		if (err_total == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// One classic cycle; holds the request until ack is sampled
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		if (wb_ack_o !== 1'b1) begin
			err_total++;
			conclude();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic chk_st(input logic [2:0] st, input logic [2:0] cs);
		xfer(1'b0, REG_STATUS, 32'h0);
		`CHK(q[2:0], st)
		`CHK(q[6:4], cs)
	endtask
	// Polls until fast-charge is left, then checks the latched cause
	task automatic wait_end(input logic [2:0] cs, input int lim);
		int n = 0;
		do begin
			xfer(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (q[2:0] === ST_FAST && n < lim);
		if (q[2:0] === ST_FAST) begin
			err_total++;
			conclude();
		end
		`CHK(q[6:4], cs)
	endtask
	task automatic count_hi(input bit led, input int n);
		hi = 0;
		repeat (n) begin
			@(posedge clk_i);
			hi += led ? status_led_out_o : charge_switch_out_o;
		end
	endtask
	task automatic t_regs();
		xfer(1'b0, REG_CTRL, 32'h0);
		`CHK(q, 32'h0)
		chk_st(ST_PENDING, CAUSE_NONE);
		`CHK(q[ST_TOPOFF_EN_BIT], 1'b0)
		rate_select_a_i <= 2'h2;
		rate_select_b_i <= 2'h2;
		cyc(2);
		xfer(1'b1, REG_STATUS, 32'hFFFF_FFFF);
		chk_st(ST_PENDING, CAUSE_NONE);
		`CHK(q[ST_TOPOFF_EN_BIT], 1'b1)
		xfer(1'b1, 8'h08, 32'hFF);
		xfer(1'b0, 8'h08, 32'h0);
		`CHK(q, 32'h0)
		xfer(1'b1, REG_CTRL, 32'hA4);
		xfer(1'b0, REG_CTRL, 32'h0);
		`CHK(q[7:0], 8'hA4)
		xfer(1'b1, REG_CTRL, 32'h0);
	endtask
	task automatic t_disch();
		discharge_command_in_i <= 1'b1;
		cyc(2);
		`CHK(discharge_drive_out_o, 1'b1)
		cyc(12 * TC);
		count_hi(1'b1, 2 * TC * (LED_LONG_MS + LED_SHORT_MS) / TICK_PERIOD_MS);
		`CHK(hi, 2 * TC * LED_SHORT_MS / TICK_PERIOD_MS)
		cell_voltage_in_i <= 12'h2BC;
		cyc(2);
		`CHK(discharge_drive_out_o, 1'b0)
		cell_voltage_in_i <= 12'h5DC;
		discharge_command_in_i <= 1'b0;
		chk_st(ST_FAST, CAUSE_NONE);
	endtask
	task automatic t_hyst();
		count_hi(1'b0, 200);
		`CHK(hi > 0 && hi < 200, 1'b1)
		gnd <= 1'b1;
		xfer(1'b1, REG_CTRL, 32'h1);
		count_hi(1'b0, 200);
		`CHK(hi, 200)
	endtask
	task automatic t_vmax();
		cell_voltage_in_i <= 12'h6A4;
		cyc(20);
		chk_st(ST_FAST, CAUSE_NONE);
		wait_end(CAUSE_VOLT_MAX, 1500);
		cell_voltage_in_i <= 12'h5DC;
	endtask
	task automatic t_rise();
		charge_command_in_i <= 1'b1;
		cyc(2);
		`CHK(status_led_out_o, 1'b0)
		chk_st(ST_FAST, CAUSE_NONE);
		thermistor_in_i <= 12'h384;
		wait_end(CAUSE_TEMP_HIGH, 10);
		thermistor_in_i <= 12'h514;
	endtask
	task automatic t_fall();
		battery_present_i <= 1'b0;
		discharge_command_in_i <= 1'b1;
		cyc(2);
		battery_present_i <= 1'b1;
		cyc(2);
		charge_command_in_i <= 1'b0;
		cyc(2);
		`CHK(status_led_out_o, 1'b0)
		chk_st(ST_FAST, CAUSE_NONE);
		thermistor_in_i <= 12'h6A4;
		wait_end(CAUSE_TEMP_LOW, 10);
		thermistor_in_i <= 12'h514;
		discharge_command_in_i <= 1'b0;
	endtask
	// Drop during hold-off is ignored; drop after it ends the charge
	task automatic t_ndv();
		charge_command_in_i <= 1'b1;
		cyc(1200);
		cell_voltage_in_i <= 12'h5C8;
		cyc(1900);
		chk_st(ST_FAST, CAUSE_NONE);
		cell_voltage_in_i <= 12'h5DC;
		cyc(1300);
		cell_voltage_in_i <= 12'h5D2;
		wait_end(CAUSE_NDV, 700);
		`CHK(q[2:0], ST_TOPOFF)
	endtask
	task automatic t_topoff();
		count_hi(1'b0, TC * (TOPOFF_ON_MS + TOPOFF_OFF_MS) / TICK_PERIOD_MS);
		`CHK(hi, TC * TOPOFF_ON_MS / TICK_PERIOD_MS)
		count_hi(1'b1, 8 * TC);
		`CHK(hi, 4 * TC)
	endtask
	// Pulsed variant: slope sampled every 544 ticks, drop lands between samples one and two
	task automatic t_slope();
		xfer(1'b1, REG_CTRL, 32'h3);
		charge_command_in_i <= 1'b0;
		cyc(2);
		charge_command_in_i <= 1'b1;
		cyc(2300);
		thermistor_in_i <= 12'h500;
		cyc(1500);
		chk_st(ST_FAST, CAUSE_NONE);
		wait_end(CAUSE_SLOPE, 1500);
		`CHK(q[2:0], ST_TOPOFF)
		count_hi(1'b0, TC * (TOPOFF_A_ON_MS + TOPOFF_A_OFF_MS) / TICK_PERIOD_MS);
		`CHK(hi, TC * TOPOFF_A_ON_MS / TICK_PERIOD_MS)
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_disch();
		t_hyst();
		t_vmax();
		t_rise();
		t_fall();
		t_ndv();
		t_topoff();
		t_slope();
		conclude();
	end
endmodule // testbench
`default_nettype wire
